/* File: design/nvm_readback_pkg.sv */
/*
  constants for the fuse/lock/signature read-back block: control register
  layout, pointer codes, window lengths and flash write timing.
  assumes a 20 MHz core clock.
*/
package nvm_readback_pkg;
  localparam logic [5:0] CTRL_ADDR = 6'h37;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int SIGNATURE_READ_BIT_POS = 5;
  localparam int LOCK_FUSE_SELECT_BIT_POS = 3;
  localparam int PGWRT_POS = 2;
  localparam int PGERS_POS = 1;
  localparam int SELFPROG_ENABLE_BIT_POS = 0;
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] PTR_SIG1 = 16'h0000;
  localparam logic [15:0] PTR_CAL = 16'h0001;
  localparam logic [15:0] PTR_SIG2 = 16'h0002;
  localparam logic [15:0] PTR_SIG3 = 16'h0004;
  localparam logic [2:0] READ_WINDOW = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [7:0] LOCK_UNUSED_MASK = 8'h3F;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'h07;
  localparam int CLK_HZ = 20000000;
  localparam int WRITE_MIN_US = 3700;
  localparam int WRITE_MAX_US = 4500;
  localparam int WRITE_CYCLES_MIN = (CLK_HZ / 1000 * WRITE_MIN_US + 999) / 1000;
  localparam int WRITE_CYCLES_MAX = CLK_HZ / 1000 * WRITE_MAX_US / 1000;
  localparam int WRITE_CYCLES_NOM = (WRITE_CYCLES_MIN + WRITE_CYCLES_MAX) / 2;
endpackage

/* File: design/nvm_readback.sv */
/*
  fuse, lock and signature read-back path with the self-programming control
  register and flash write timer.
  assumes the core drives program-memory loads and stores as one-cycle
  strobes, the nonvolatile values arrive as static inputs, all synchronous.
*/
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
module nvm_readback
  import nvm_readback_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_NOM
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  input wire logic [15:0] z_ptr,
  input wire logic lpm_req,
  input wire logic spm_req,
  input wire logic [7:0] pmem_byte,
  output logic [7:0] lpm_data,
  input wire logic [7:0] lock_bits,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  input wire logic [7:0] fuse_extended_byte,
  input wire logic [7:0] sig_byte1,
  input wire logic [7:0] sig_byte2,
  input wire logic [7:0] sig_byte3,
  input wire logic [7:0] osc_cal_byte,
  input wire logic eeprom_write_active_flag,
  output logic flash_busy,
  output logic flash_write_strobe
);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [2:0] win_q;
  logic [2:0] win_d;
  logic [7:0] lpm_data_q;
  logic [7:0] io_rdata_q;
  logic [22:0] wtime_q;
  logic busy_q;
  logic start_q;

  wire ctrl_wr = io_wr && io_addr == CTRL_ADDR;
  wire ctrl_wr_ok = ctrl_wr && !eeprom_write_active_flag;
  wire selfprog_enable_bit = ctrl_q[SELFPROG_ENABLE_BIT_POS];
  wire lock_fuse_select_bit = ctrl_q[LOCK_FUSE_SELECT_BIT_POS];
  wire signature_read_bit = ctrl_q[SIGNATURE_READ_BIT_POS];
  wire lock_armed = selfprog_enable_bit && lock_fuse_select_bit;
  wire sig_armed = selfprog_enable_bit && signature_read_bit;
  wire lock_read = lock_armed && lpm_req && win_q < READ_WINDOW;
  wire sig_read = sig_armed && lpm_req && win_q < READ_WINDOW;
  wire read_expired = (lock_armed || sig_armed) && win_q >= READ_WINDOW;
  wire store_cmd = selfprog_enable_bit && !signature_read_bit && spm_req
                   && win_q < STORE_WINDOW && !busy_q;
  wire write_cmd = store_cmd && (ctrl_q[PGERS_POS] || ctrl_q[PGWRT_POS]
                   || lock_fuse_select_bit);
  wire store_expired = selfprog_enable_bit && win_q >= STORE_WINDOW;

  // lock/fuse read: the read window closes after three cycles but the lock
  // enables stay set until the store window ends, so a store can come in the fourth
  wire lock_timeout = lock_armed && read_expired && store_expired;
  wire clear_enables = lock_read || sig_read || store_cmd
                       || (sig_armed && read_expired)
                       || lock_timeout
                       || (!lock_armed && !sig_armed && store_expired);

  always_comb
  begin
    ctrl_d = ctrl_q;
    win_d = win_q;
    if (ctrl_wr_ok)
    begin
      ctrl_d = io_wdata;
      win_d = '0;
    end
    else if (clear_enables)
    begin
      ctrl_d[SELFPROG_ENABLE_BIT_POS] = 1'b0;
      ctrl_d[LOCK_FUSE_SELECT_BIT_POS] = 1'b0;
      ctrl_d[SIGNATURE_READ_BIT_POS] = 1'b0;
      ctrl_d[PGERS_POS] = 1'b0;
      ctrl_d[PGWRT_POS] = 1'b0;
    end
    else if (selfprog_enable_bit && win_q < STORE_WINDOW)
    begin
      win_d = win_q + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RESET;
      win_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      win_q <= win_d;
    end
  end

  // ----------------------------------------------------------------
  // load data selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] fuse_sel(input logic [15:0] p, input logic [7:0] lk,
    input logic [7:0] fl, input logic [7:0] fh, input logic [7:0] fe, input logic [7:0] pm);
    case (p)
      PTR_LOCK: fuse_sel = (lk & LOCK_UNUSED_MASK) | ~LOCK_UNUSED_MASK;
      PTR_FUSE_LOW: fuse_sel = fl;
      PTR_FUSE_HIGH: fuse_sel = fh;
      PTR_FUSE_EXT: fuse_sel = (fe & EXT_UNUSED_MASK) | ~EXT_UNUSED_MASK;
      default: fuse_sel = pm;
    endcase
  endfunction

  function automatic logic [7:0] sig_sel(input logic [15:0] p, input logic [7:0] s1,
    input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] cal);
    case (p)
      PTR_SIG1: sig_sel = s1;
      PTR_SIG2: sig_sel = s2;
      PTR_SIG3: sig_sel = s3;
      PTR_CAL: sig_sel = cal;
      default: sig_sel = 8'hFF; // reserved rows read as erased
    endcase
  endfunction

  // values are passed through uninverted: a programmed bit is already 0
  wire [7:0] fuse_word = fuse_sel(z_ptr, lock_bits, fuse_low_byte, fuse_high_byte,
                                  fuse_extended_byte, pmem_byte);
  wire [7:0] sig_word = sig_sel(z_ptr, sig_byte1, sig_byte2, sig_byte3, osc_cal_byte);
  wire fuse_ok = lock_read && !eeprom_write_active_flag;
  wire [7:0] load_word = fuse_ok ? fuse_word :
                         sig_read ? sig_word : pmem_byte;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lpm_data_q <= 8'h00;
    else if (lpm_req)
      lpm_data_q <= load_word;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      io_rdata_q <= 8'h00;
    else if (io_rd && io_addr == CTRL_ADDR)
      io_rdata_q <= ctrl_q;
    else
      io_rdata_q <= 8'h00;
  end

  // ----------------------------------------------------------------
  // flash write timer
  // ----------------------------------------------------------------
  // the timer ignores sys_rst so a write in flight still completes
  logic timer_init_q = 1'b0;
  always_ff @(posedge clk)
  begin
    timer_init_q <= 1'b1;
    start_q <= 1'b0;
    if (!timer_init_q)
    begin
      busy_q <= 1'b0;
      wtime_q <= '0;
    end
    else if (write_cmd && !busy_q && !eeprom_write_active_flag)
    begin
      busy_q <= 1'b1;
      start_q <= 1'b1;
      wtime_q <= 23'(WRITE_CYCLES - 1);
    end
    else if (busy_q)
    begin
      if (wtime_q == '0)
        busy_q <= 1'b0;
      else
        wtime_q <= wtime_q - 23'h1;
    end
  end

  assign io_rdata = io_rdata_q;
  assign lpm_data = lpm_data_q;
  assign flash_busy = busy_q;
  assign flash_write_strobe = start_q;

  // ----------------------------------------------------------------
  // check helper: length of the current flash write
  // ----------------------------------------------------------------
  // counts busy cycles so one check can cover the whole write, however long
  logic [22:0] busy_len_q;
  always_ff @(posedge clk)
  begin
    if (start_q)
      busy_len_q <= 23'h1;
    else if (busy_q)
      busy_len_q <= busy_len_q + 23'h1;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LOCK_READ: assert property (@(posedge clk) disable iff (sys_rst)
    lock_read && z_ptr == PTR_LOCK && !eeprom_write_active_flag
      |=> lpm_data[5:0] == $past(lock_bits[5:0]) && lpm_data[7:6] == 2'b11)
    else $error("lock bits not returned");
  AST_AUTOCLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(lock_armed) |-> ##[1:5] !selfprog_enable_bit)
    else $error("lock enables did not auto-clear");
  AST_NORMAL_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    lpm_req && !lock_armed && !sig_armed |=> lpm_data == $past(pmem_byte))
    else $error("disarmed load not from program memory");
  AST_FUSE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    fuse_ok && z_ptr == PTR_FUSE_HIGH |=> lpm_data == $past(fuse_high_byte))
    else $error("fuse high byte wrong");
  AST_EXT_FUSE: assert property (@(posedge clk) disable iff (sys_rst)
    fuse_ok && z_ptr == PTR_FUSE_EXT |=> lpm_data[7:3] == 5'h1F)
    else $error("extended fuse upper bits not one");
  AST_SIG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    sig_read && !ctrl_wr_ok |=> !signature_read_bit && !selfprog_enable_bit)
    else $error("signature enables not cleared");
  AST_SIG_CAL: assert property (@(posedge clk) disable iff (sys_rst)
    sig_read && z_ptr == PTR_CAL |=> lpm_data == $past(osc_cal_byte))
    else $error("calibration byte wrong");
  AST_EE_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && eeprom_write_active_flag && !clear_enables |=> ctrl_q == $past(ctrl_q))
    else $error("control written during eeprom write");
  AST_RESET_ZERO: assert property (@(posedge clk)
    sys_rst |=> ctrl_q == CTRL_RESET)
    else $error("control register not reset");
  AST_BUSY_HOLD: assert property (@(posedge clk)
    start_q |-> busy_q [*8])
    else $error("flash write ended too soon");
  AST_FUSE_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    fuse_ok && z_ptr == PTR_FUSE_LOW |=> lpm_data == $past(fuse_low_byte))
    else $error("fuse low byte wrong");
  AST_EXT_LOW: assert property (@(posedge clk) disable iff (sys_rst)
    fuse_ok && z_ptr == PTR_FUSE_EXT |=> lpm_data[2:0] == $past(fuse_extended_byte[2:0]))
    else $error("extended fuse bits wrong");
  AST_LOCK_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    lock_read && !ctrl_wr_ok |=> !selfprog_enable_bit && !lock_fuse_select_bit)
    else $error("lock enables not cleared after read");
  AST_STORE_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
    lock_armed && win_q >= STORE_WINDOW && !ctrl_wr_ok |=> !selfprog_enable_bit)
    else $error("lock enables not cleared after store window");
  AST_SIG_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
    sig_armed && win_q >= READ_WINDOW && !ctrl_wr_ok |=> !selfprog_enable_bit)
    else $error("signature enables not cleared after read window");
  AST_SIG_BYTE1: assert property (@(posedge clk) disable iff (sys_rst)
    sig_read && z_ptr == PTR_SIG1 |=> lpm_data == $past(sig_byte1))
    else $error("signature byte one wrong");
  AST_SIG_BYTE2: assert property (@(posedge clk) disable iff (sys_rst)
    sig_read && z_ptr == PTR_SIG2 |=> lpm_data == $past(sig_byte2))
    else $error("signature byte two wrong");
  AST_SIG_BYTE3: assert property (@(posedge clk) disable iff (sys_rst)
    sig_read && z_ptr == PTR_SIG3 |=> lpm_data == $past(sig_byte3))
    else $error("signature byte three wrong");
  AST_WIN_START: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr_ok |=> win_q == 3'h0)
    else $error("window not restarted by control write");
  AST_WIN_BOUND: assert property (@(posedge clk) disable iff (sys_rst)
    win_q <= STORE_WINDOW)
    else $error("window counter ran past the store window");
  AST_EE_FUSE: assert property (@(posedge clk) disable iff (sys_rst)
    lpm_req && lock_armed && eeprom_write_active_flag |=> lpm_data == $past(pmem_byte))
    else $error("fuse read not blocked during eeprom write");
  AST_EE_NO_WRITE: assert property (@(posedge clk)
    eeprom_write_active_flag && !busy_q |=> !start_q)
    else $error("flash write started during eeprom write");
  AST_STROBE_PULSE: assert property (@(posedge clk)
    start_q |=> !start_q)
    else $error("write strobe longer than one cycle");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    !io_rd |=> io_rdata == 8'h00)
    else $error("read data not zero when idle");
  AST_RDATA_CTRL: assert property (@(posedge clk) disable iff (sys_rst)
    io_rd && io_addr == CTRL_ADDR |=> io_rdata == $past(ctrl_q))
    else $error("control register read back wrong");
  // no reset here: a write in flight keeps its full length through sys_rst
  AST_BUSY_LEN: assert property (@(posedge clk)
    busy_q ##1 !busy_q |-> busy_len_q == 23'(WRITE_CYCLES))
    else $error("flash write length wrong");

endmodule

/* File: verification/pmem_model.sv */
/*
  program memory seen by the core for the read-back bench.
  assumes the byte follows the pointer within the same cycle.
*/
`timescale 1ns/100ps
module pmem_model
(
  input wire logic [15:0] z_ptr,
  output logic [7:0] pmem_byte
);
  // pattern kept apart from every nonvolatile value in the bench
  assign pmem_byte = z_ptr[7:0] ^ 8'hA5;
endmodule

/* File: verification/fuse_lock_signature_readback_tb_top.sv */
/*
  self-checking bench for the fuse, lock and signature read-back block.
  assumes the package constants and a 20 MHz clock.
*/
`timescale 1ns/100ps
module fuse_lock_signature_readback_tb_top
  import nvm_readback_pkg::*;
;
  localparam int WC = 20;
  logic clk = 1'b0, sys_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic lpm_req = 1'b0, spm_req = 1'b0, ee_busy = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, rd_val;
  logic [15:0] z_ptr = 16'h0000;
  logic [7:0] lock_v = 8'h5A, flo = 8'hC3, fhi = 8'h99, fext = 8'h35;
  // signature values are arbitrary
  logic [7:0] s1 = 8'h11, s2 = 8'h22, s3 = 8'h33, cal = 8'h44;
  logic [7:0] exp_lf [4], exp_sg [4];
  logic [15:0] sp [4];
  wire [7:0] io_rdata, lpm_data, pmem_byte;
  wire flash_busy, flash_write_strobe;
  int n_mismatch = 0, n_compared = 0, cyc = 0, i, nb, ns;

  always #25 clk = ~clk;

  pmem_model pm (.z_ptr(z_ptr), .pmem_byte(pmem_byte));
  nvm_readback #(.WRITE_CYCLES(WC)) dut (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .z_ptr(z_ptr),
    .lpm_req(lpm_req), .spm_req(spm_req), .pmem_byte(pmem_byte), .lpm_data(lpm_data),
    .lock_bits(lock_v), .fuse_low_byte(flo), .fuse_high_byte(fhi),
    .fuse_extended_byte(fext), .sig_byte1(s1), .sig_byte2(s2), .sig_byte3(s3),
    .osc_cal_byte(cal), .eeprom_write_active_flag(ee_busy), .flash_busy(flash_busy),
    .flash_write_strobe(flash_write_strobe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1 rd_val = io_rdata;
  endtask

  // gap counts idle cycles after the arming write before the load
  task automatic ld(input logic [15:0] z, input int gap);
    repeat (gap) @(posedge clk);
    lpm_req <= 1'b1;
    z_ptr <= z;
    @(posedge clk);
    lpm_req <= 1'b0;
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // hang guard
  // ---------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    exp_lf = '{flo, {2'b11, lock_v[5:0]}, {5'h1F, fext[2:0]}, fhi};
    exp_sg = '{s1, s2, s3, cal};
    sp = '{PTR_SIG1, PTR_SIG2, PTR_SIG3, PTR_CAL};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CTRL_ADDR);
    chk(rd_val, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(CTRL_ADDR, 8'h09);
      ld(16'(i), 0);
      chk(lpm_data, exp_lf[i]);
      rd(CTRL_ADDR);
      chk(rd_val, 8'h00);
    end
    ld(16'h0001, 0);
    chk(lpm_data, 8'hA4);
    $display("lock and fuse reads done");
    for (i = 0; i < 4; i++)
    begin
      wr(CTRL_ADDR, 8'h21);
      ld(sp[i], i % 3);
      chk(lpm_data, exp_sg[i]);
      rd(CTRL_ADDR);
      chk(rd_val, 8'h00);
    end
    ld(16'h0004, 0);
    chk(lpm_data, 8'hA1);
    $display("signature reads done");
    wr(CTRL_ADDR, 8'h21);
    ld(16'h0000, 3);
    chk(lpm_data, 8'hA5);
    wr(CTRL_ADDR, 8'h09);
    ld(16'h0001, 3);
    chk(lpm_data, 8'hA4);
    repeat (2) @(posedge clk);
    rd(CTRL_ADDR);
    chk(rd_val, 8'h00);
    ee_busy <= 1'b1;
    wr(CTRL_ADDR, 8'h09);
    ld(16'h0001, 0);
    chk(lpm_data, 8'hA4);
    ee_busy <= 1'b0;
    $display("window expiry and blocking done");
    wr(CTRL_ADDR, 8'h05);
    spm_req <= 1'b1;
    nb = 0;
    ns = 0;
    // reset lands mid-write; the timer must ride through it
    for (i = 0; i < 60; i++)
    begin
      @(posedge clk);
      #1;
      if (i == 0)
        spm_req <= 1'b0;
      if (i == 6)
        sys_rst <= 1'b1;
      if (i == 8)
        sys_rst <= 1'b0;
      if (flash_busy === 1'b1)
        nb++;
      if (flash_write_strobe === 1'b1)
        ns++;
    end
    chk({7'h00, nb >= WC && nb <= WC + 1}, 8'h01);
    chk(8'(ns), 8'h01);
    $display("flash write timing done");
    tally_and_finish();
  end
endmodule
